// file: src/tmb_map.vh
// Function
// (R1) Periodic and PWM modes ignore all events.
// (R2) Timeout mode: one edge starts, other stops.
// (R3) Capture mode: selected edge captures, sets flag.
// (R4) Frequency mode: capture, clear, restart, set flag.
// (R5) Pulse-width mode: one edge clears, other captures.
// (R6) Combined mode: clear, capture, then stop and flag.
// (R7) Single-shot: selected edge starts; flag at top.
// (R8) Periodic and timeout: flag at compare top.
// (R9) PWM mode: flag when count meets high byte.
// (R10) Events act only with event input enabled.
// (R11) Enable bit 0 gates the capture interrupt.
// (R12) Flag clears by write one, capture read.
// (R13) Read-only run bit shows counter running.
// (R14) Debug halt stops block unless bypass set.
// (R15) One shared byte latch for 16-bit access.
// (R16) Count low at base, high at base+1.
// (R17) Bus write to count beats internal update.
// (R18) Interrupt asserted while flag and enable set.
// (R19) Mode field encodes eight modes 0 to 7.
// (R20) Compare holds capture, top, or two bytes.
// (R21) Read low first, write high first.
// (R22) Combined mode ignores edges until flag cleared.
`ifndef TMB_MAP_VH
`define TMB_MAP_VH

// Register indices; byte address is four times the index.
`define TMB_IDX_CTRL_A   4'h0
`define TMB_IDX_CTRL_B   4'h1
`define TMB_IDX_EVCTL    4'h4
`define TMB_IDX_IRQEN    4'h5
`define TMB_IDX_FLAGS    4'h6
`define TMB_IDX_RUN      4'h7
`define TMB_IDX_DBG      4'h8
`define TMB_IDX_LATCH    4'h9
`define TMB_IDX_CNT_LO   4'hA
`define TMB_IDX_CNT_HI   4'hB
`define TMB_IDX_CMP_LO   4'hC
`define TMB_IDX_CMP_HI   4'hD

// Field positions.
`define TMB_ENABLE_BIT   0
`define TMB_MODE_HI      2
`define TMB_MODE_LO      0
`define TMB_EDGE_BIT     4
`define TMB_EVEN_BIT     0
`define TMB_IRQ_BIT      0
`define TMB_RUN_BIT      0
`define TMB_BYPASS_BIT   0
`define TMB_IDX_MSB      5
`define TMB_IDX_LSB      2
`define TMB_ALIGN_MSB    1

// Reset values.
`define TMB_BYTE_RST     8'h00
`define TMB_WORD_RST     16'h0000
`define TMB_MODE_RST     3'h0

// Timer operating modes.
`define TMB_MODE_PERIODIC 3'h0
`define TMB_MODE_TIMEOUT  3'h1
`define TMB_MODE_CAPTURE  3'h2
`define TMB_MODE_FREQ     3'h3
`define TMB_MODE_PWIDTH   3'h4
`define TMB_MODE_FREQ_PW  3'h5
`define TMB_MODE_SINGLE   3'h6
`define TMB_MODE_PWM8     3'h7

// Combined-mode sequence states.
`define TMB_FPW_WAIT     2'h0
`define TMB_FPW_PULSE    2'h1
`define TMB_FPW_PERIOD   2'h2
`define TMB_FPW_DONE     2'h3

`define TMB_CNT_ONE      16'h0001

`endif

// file: src/tmb_event_capture.v
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "tmb_map.vh"

module tmb_event_capture #(
  parameter AW = 12
) (
  // APB slave
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output wire          pready,
  output reg  [31:0]   prdata,
  output reg           pslverr,
  // Event network and debug
  input  wire          event_in,
  input  wire          cpu_debug_halt,
  // Interrupt request
  output wire          sample_irq
);

  // Register state.
  reg          enable_q;
  reg  [2:0]   timer_operating_mode;
  reg          edge_pol_q;
  reg          event_sample_input_enable;
  reg          irq_en_q;
  reg          flag_q;
  reg          halt_bypass;
  reg  [7:0]   latch_q;
  reg  [15:0]  cnt_q;
  reg  [15:0]  compare_or_sample_value_q;
  reg          run_q;
  reg  [1:0]   fpw_q;
  reg          ev_q;

  // Next values.
  reg  [15:0]  cnt_d;
  reg  [15:0]  compare_or_sample_value_d;
  reg          run_d;
  reg  [1:0]   fpw_d;
  reg          flag_set;
  reg          flag_d;
  reg  [7:0]   latch_d;
  reg  [7:0]   rd_b;
  reg          rd_ok;

  // Only aligned offsets inside the index range decode; any other address bit is an error.
  wire [3:0]   idx      = paddr[`TMB_IDX_MSB:`TMB_IDX_LSB];
  wire         hi_zero  = (paddr[AW-1:`TMB_IDX_MSB+1] == {(AW-`TMB_IDX_MSB-1){1'b0}}) &&
                          (paddr[`TMB_ALIGN_MSB:0] == 2'b00);
  wire         setup    = psel & ~penable;
  wire         access   = psel & penable;
  // The error flop was loaded at the setup edge, so it speaks for this very transfer.
  wire         wr       = access & pwrite & ~pslverr;
  wire         rd       = access & ~pwrite & ~pslverr;
  wire [7:0]   wbyte    = pwdata[7:0];

  // A debug halt freezes the count and the edge logic but leaves the bus usable.
  wire         halted   = cpu_debug_halt & ~halt_bypass; // R14
  wire         ev_ok    = event_sample_input_enable & enable_q & ~halted; // R10 R14
  wire         rise     = ev_ok & event_in & ~ev_q;
  wire         fall     = ev_ok & ~event_in & ev_q;
  wire         sel_edge = edge_pol_q ? fall : rise;
  wire         opp_edge = edge_pol_q ? rise : fall;
  // The wrap happens on the cycle after the match, so a period is top plus one cycles.
  wire         at_top   = (cnt_q == compare_or_sample_value_q);
  wire         pwm8     = (timer_operating_mode == `TMB_MODE_PWM8);
  // In these modes the compare register holds a sample, and reading it clears the flag.
  wire         cap_mode = (timer_operating_mode == `TMB_MODE_CAPTURE) ||
                          (timer_operating_mode == `TMB_MODE_FREQ)    ||
                          (timer_operating_mode == `TMB_MODE_PWIDTH)  ||
                          (timer_operating_mode == `TMB_MODE_FREQ_PW);

  // Bus-side register strobes.
  wire         wr_cnt_lo = wr & (idx == `TMB_IDX_CNT_LO);
  wire         wr_cmp_lo = wr & (idx == `TMB_IDX_CMP_LO);
  wire         wr_cmp_hi = wr & (idx == `TMB_IDX_CMP_HI);
  wire         rd_cmp_lo = rd & (idx == `TMB_IDX_CMP_LO);
  wire         clr_w1c   = wr & (idx == `TMB_IDX_FLAGS) & pwdata[`TMB_IRQ_BIT]; // R12
  wire         clr_read  = rd_cmp_lo & cap_mode; // R12
  // The high byte is taken at the setup edge, with the low byte that prdata takes there,
  // so a running count cannot carry between the two halves.
  wire         rd_setup  = setup & ~pwrite & rd_ok;

  // Zero wait states: every transfer completes in its first access cycle.
  assign pready     = 1'b1;
  // Built from two flops only, so the request drops in the cycle the flag clears.
  assign sample_irq = flag_q & irq_en_q; // R11 R18

  // Counter, capture and run control.
  // The count advances on every clock while running; there is no prescaler.
  always @* begin
    cnt_d    = cnt_q;
    compare_or_sample_value_d   = compare_or_sample_value_q;
    run_d    = run_q;
    fpw_d    = fpw_q;
    flag_set = 1'b0;
    if (!enable_q) begin
      run_d = 1'b0;
      fpw_d = `TMB_FPW_WAIT;
    end else if (!halted) begin // R14
      // Leaving the combined mode drops any half-done sequence, so it restarts cleanly.
      if (timer_operating_mode != `TMB_MODE_FREQ_PW) begin
        fpw_d = `TMB_FPW_WAIT;
      end
      case (timer_operating_mode) // R19
        `TMB_MODE_PERIODIC: begin
          // Events are not looked at here.
          run_d = 1'b1; // R1
          if (run_q) begin
            if (at_top) begin
              cnt_d    = `TMB_WORD_RST;
              flag_set = 1'b1; // R8
            end else begin
              cnt_d = cnt_q + `TMB_CNT_ONE;
            end
          end
        end
        `TMB_MODE_TIMEOUT: begin
          // Start and stop only gate counting; a stop keeps the count.
          if (sel_edge) begin
            run_d = 1'b1; // R2
          end else if (opp_edge) begin
            run_d = 1'b0; // R2
          end
          if (run_q) begin
            if (at_top) begin
              cnt_d    = `TMB_WORD_RST;
              flag_set = 1'b1; // R8
            end else begin
              cnt_d = cnt_q + `TMB_CNT_ONE;
            end
          end
        end
        `TMB_MODE_CAPTURE: begin
          run_d = 1'b1;
          if (run_q) begin
            cnt_d = cnt_q + `TMB_CNT_ONE;
          end
          if (sel_edge) begin
            compare_or_sample_value_d   = cnt_q; // R3 R20
            flag_set = 1'b1; // R3
          end
        end
        `TMB_MODE_FREQ: begin
          // The opposite edge is ignored in this mode.
          run_d = 1'b1;
          if (sel_edge) begin
            compare_or_sample_value_d   = cnt_q; // R4
            cnt_d    = `TMB_WORD_RST; // R4
            flag_set = 1'b1; // R4
          end else if (run_q) begin
            cnt_d = cnt_q + `TMB_CNT_ONE;
          end
        end
        `TMB_MODE_PWIDTH: begin
          run_d = 1'b1;
          if (sel_edge) begin
            cnt_d = `TMB_WORD_RST; // R5
          end else begin
            if (opp_edge) begin
              compare_or_sample_value_d   = cnt_q; // R5
              flag_set = 1'b1; // R5
            end
            if (run_q) begin
              cnt_d = cnt_q + `TMB_CNT_ONE;
            end
          end
        end
        `TMB_MODE_FREQ_PW: begin
          case (fpw_q)
            `TMB_FPW_WAIT: begin
              run_d = 1'b1;
              if (sel_edge) begin
                cnt_d = `TMB_WORD_RST; // R6
                fpw_d = `TMB_FPW_PULSE;
              end else if (run_q) begin
                cnt_d = cnt_q + `TMB_CNT_ONE;
              end
            end
            `TMB_FPW_PULSE: begin
              // The counter runs on through the pulse and period phases.
              if (opp_edge) begin
                compare_or_sample_value_d = cnt_q; // R6
                fpw_d  = `TMB_FPW_PERIOD;
              end
              cnt_d = cnt_q + `TMB_CNT_ONE;
            end
            `TMB_FPW_PERIOD: begin
              if (sel_edge) begin
                run_d    = 1'b0; // R6
                flag_set = 1'b1; // R6
                fpw_d    = `TMB_FPW_DONE;
              end else begin
                cnt_d = cnt_q + `TMB_CNT_ONE;
              end
            end
            `TMB_FPW_DONE: begin
              // Edges are dropped until the result has been collected.
              run_d = 1'b0; // R22
              if (!flag_q) begin
                fpw_d = `TMB_FPW_WAIT; // R22
                run_d = 1'b1;
              end
            end
            default: begin
              fpw_d = `TMB_FPW_WAIT;
            end
          endcase
        end
        `TMB_MODE_SINGLE: begin
          // A start edge while the counter runs is ignored.
          if (!run_q && sel_edge) begin
            run_d = 1'b1; // R7
          end
          if (run_q) begin
            if (at_top) begin
              run_d    = 1'b0;
              cnt_d    = `TMB_WORD_RST;
              flag_set = 1'b1; // R7
            end else begin
              cnt_d = cnt_q + `TMB_CNT_ONE;
            end
          end
        end
        `TMB_MODE_PWM8: begin
          // Low compare byte is the period, high byte the match point.
          // The wrap clears the whole count, so a stale high byte lasts one period at most.
          run_d = 1'b1; // R1
          if (run_q) begin
            if (cnt_q[7:0] == compare_or_sample_value_q[7:0]) begin
              cnt_d = `TMB_WORD_RST; // R20
            end else begin
              cnt_d = cnt_q + `TMB_CNT_ONE;
            end
            if (cnt_q[7:0] == compare_or_sample_value_q[15:8]) begin
              flag_set = 1'b1; // R9
            end
          end
        end
        default: begin
          run_d = 1'b0;
        end
      endcase
    end
    // A bus write overrides whatever the counter logic computed this cycle.
    if (wr_cnt_lo) begin
      cnt_d = {latch_q, wbyte}; // R17 R21
    end
    if (wr_cmp_lo) begin
      if (pwm8) begin
        compare_or_sample_value_d[7:0] = wbyte; // R20
      end else begin
        compare_or_sample_value_d = {latch_q, wbyte}; // R21
      end
    end
    if (wr_cmp_hi && pwm8) begin
      compare_or_sample_value_d[15:8] = wbyte; // R20
    end
  end

  // Hardware setting wins over software clearing in the same cycle.
  always @* begin
    flag_d = flag_set | (flag_q & ~(clr_w1c | clr_read)); // R12
  end

  // Shared byte latch: low-byte reads fill it, high-byte writes fill it except compare high in PWM mode.
  always @* begin
    latch_d = latch_q;
    if (wr) begin
      if (idx == `TMB_IDX_LATCH) begin
        latch_d = wbyte; // R15
      end else if ((idx == `TMB_IDX_CNT_HI) || (idx == `TMB_IDX_CMP_HI && !pwm8)) begin
        latch_d = wbyte; // R21
      end
    end else if (rd_setup) begin
      if (idx == `TMB_IDX_CNT_LO) begin
        latch_d = cnt_q[15:8]; // R21
      end else if (idx == `TMB_IDX_CMP_LO) begin
        latch_d = compare_or_sample_value_q[15:8]; // R21
      end
    end
  end

  // Read data selection, sampled in the setup cycle.
  // Unmapped indices answer with an error and read as zero.
  always @* begin
    rd_b  = `TMB_BYTE_RST;
    rd_ok = hi_zero;
    case (idx)
      `TMB_IDX_CTRL_A: rd_b[`TMB_ENABLE_BIT] = enable_q;
      `TMB_IDX_CTRL_B: rd_b[`TMB_MODE_HI:`TMB_MODE_LO] = timer_operating_mode;
      `TMB_IDX_EVCTL: begin
        rd_b[`TMB_EDGE_BIT] = edge_pol_q;
        rd_b[`TMB_EVEN_BIT] = event_sample_input_enable;
      end
      `TMB_IDX_IRQEN: rd_b[`TMB_IRQ_BIT] = irq_en_q;
      `TMB_IDX_FLAGS: rd_b[`TMB_IRQ_BIT] = flag_q;
      `TMB_IDX_RUN:   rd_b[`TMB_RUN_BIT] = enable_q & run_q; // R13
      `TMB_IDX_DBG:   rd_b[`TMB_BYPASS_BIT] = halt_bypass;
      `TMB_IDX_LATCH: rd_b = latch_q; // R15
      `TMB_IDX_CNT_LO: rd_b = cnt_q[7:0]; // R16
      `TMB_IDX_CNT_HI: rd_b = latch_q; // R16 R21
      `TMB_IDX_CMP_LO: rd_b = compare_or_sample_value_q[7:0];
      `TMB_IDX_CMP_HI: rd_b = pwm8 ? compare_or_sample_value_q[15:8] : latch_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // Bus response flops.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= rd_ok ? {24'h000000, rd_b} : 32'h00000000;
      pslverr <= ~rd_ok;
    end
  end

  // Control registers; the run bit has no write path at all.
  // A mode change while enabled is accepted, but a measurement in progress is lost.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q                  <= 1'b0;
      timer_operating_mode      <= `TMB_MODE_RST;
      edge_pol_q                <= 1'b0;
      event_sample_input_enable <= 1'b0;
      irq_en_q                  <= 1'b0;
      halt_bypass               <= 1'b0;
    end else if (wr) begin
      case (idx)
        `TMB_IDX_CTRL_A: enable_q <= wbyte[`TMB_ENABLE_BIT];
        `TMB_IDX_CTRL_B: timer_operating_mode <= wbyte[`TMB_MODE_HI:`TMB_MODE_LO]; // R19
        `TMB_IDX_EVCTL: begin
          edge_pol_q                <= wbyte[`TMB_EDGE_BIT];
          event_sample_input_enable <= wbyte[`TMB_EVEN_BIT]; // R10
        end
        `TMB_IDX_IRQEN: irq_en_q <= wbyte[`TMB_IRQ_BIT]; // R11
        `TMB_IDX_DBG:   halt_bypass <= wbyte[`TMB_BYPASS_BIT]; // R14
        default: begin
        end
      endcase
    end
  end

  // Datapath registers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= `TMB_WORD_RST; // R16
      compare_or_sample_value_q  <= `TMB_WORD_RST;
      run_q   <= 1'b0;
      fpw_q   <= `TMB_FPW_WAIT;
      flag_q  <= 1'b0;
      latch_q <= `TMB_BYTE_RST;
      ev_q    <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      compare_or_sample_value_q  <= compare_or_sample_value_d;
      run_q   <= run_d;
      fpw_q   <= fpw_d;
      flag_q  <= flag_d;
      latch_q <= latch_d;
      // Tracked even while gated so a stale level never fires on enable.
      ev_q    <= event_in;
    end
  end

endmodule // tmb_event_capture

// file: tb/tmb_event_source.sv
`timescale 1ns/1ps
module tmb_event_source (
  // Requests from the bench
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level_req,
  input  wire logic halt_req,
  // Toward the timer
  output logic      event_in,
  output logic      cpu_debug_halt
);
  // The network retimes levels to pclk, so an edge never lands between clock edges.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_in       <= 1'b0;
      cpu_debug_halt <= 1'b0;
    end else begin
      event_in       <= level_req;
      cpu_debug_halt <= halt_req;
    end
  end
endmodule // tmb_event_source

// file: tb/tmb_event_capture_monitor.sv
`timescale 1ns/1ps
module tmb_event_capture_monitor #(
  parameter AW = 12
) (
  // Bus side
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  // Event side
  input wire logic          event_in,
  input wire logic          cpu_debug_halt,
  input wire logic          sample_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       setup = psel && !penable;
  wire       acc   = psel && penable;
  wire [3:0] idx   = paddr[5:2];

  a_upper_zero: assert property (prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_ready_const: assert property (acc |-> pready)
    else $error("access not ready");
  a_read_hold: assert property (!setup |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved");
  a_latch_echo: assert property ((acc && pwrite && idx == 4'h9) ##2
    (setup && !pwrite && idx == 4'h9) |=> prdata[7:0] == $past(pwdata[7:0], 3))
    else $error("latch lost data");
  a_flag_read: assert property (setup && !pwrite && idx == 4'h6 && sample_irq |=> prdata[0])
    else $error("irq without flag");
  a_enable_read: assert property (setup && !pwrite && idx == 4'h5 && sample_irq |=> prdata[0])
    else $error("irq without enable");
  a_irq_hold: assert property ($fell(sample_irq) |-> $past(acc))
    else $error("irq dropped by itself");
  a_unmapped_err: assert property (setup && (idx == 4'h2 || idx == 4'h3) |=> pslverr)
    else $error("unmapped access accepted");
  c_irq: cover property ($rose(sample_irq));
  c_err: cover property ($rose(pslverr));
  c_cap_read: cover property (setup && !pwrite && idx == 4'hC);
endmodule // tmb_event_capture_monitor

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        sample_irq;
  logic        ev;
  logic        halt;
  logic        event_in;
  logic        cpu_debug_halt;
  logic [31:0] rv;
  logic        er;
  int          err_count;
  int          comparisons;
  int          cyc;

  tmb_event_capture #(.AW(12)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .event_in(event_in),
    .cpu_debug_halt(cpu_debug_halt), .sample_irq(sample_irq));
  tmb_event_source i_src (.pclk(pclk), .presetn(presetn), .level_req(ev), .halt_req(halt),
    .event_in(event_in), .cpu_debug_halt(cpu_debug_halt));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // One idle edge before each setup keeps any signal from being driven twice in a step.
  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {6'h00, i, 2'h0};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask

  task automatic rd(input logic [3:0] i);
    apb(1'b0, i, 8'h00);
  endtask

  task automatic cfg(input logic [2:0] m, input logic e, input logic en);
    wr(4'h0, 8'h00);
    wr(4'hB, 8'h00);
    wr(4'hA, 8'h00);
    wr(4'h6, 8'h01);
    wr(4'h1, {5'h00, m});
    wr(4'h4, {3'h0, e, 3'h0, en});
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h01);
  endtask

  task automatic evw(input logic a, input int n);
    @(posedge pclk);
    ev <= a;
    repeat (n - 1) @(posedge pclk);
  endtask

  task automatic wirq(input int n);
    cyc = 0;
    do begin
      @(negedge pclk);
      cyc++;
    end while (sample_irq !== 1'b1 && cyc < n);
  endtask

  task automatic t_regs;
    for (int i = 5; i <= 10; i++) begin
      rd(i[3:0]);
      chk("reset value", rv, 32'h0);
    end
    rd(4'h2);
    chk("unmapped error", {31'h0, er}, 32'h1);
    wr(4'h7, 8'h01);
    rd(4'h7);
    chk("run read only", rv, 32'h0);
    wr(4'h9, 8'h5A);
    rd(4'h9);
    chk("latch", rv, 32'h5A);
    wr(4'hB, 8'h12);
    wr(4'hA, 8'h34);
    rd(4'hA);
    chk("count low", rv, 32'h34);
    rd(4'hB);
    chk("count high", rv, 32'h12);
    $display("test regs done");
  endtask

  task automatic t_prio;
    logic [7:0] a;
    wr(4'hD, 8'h00);
    wr(4'hC, 8'h40);
    cfg(3'h0, 1'b0, 1'b0);
    wr(4'hB, 8'h00);
    wr(4'hA, 8'h10);
    rd(4'hA);
    chk("count after write", rv, 32'h11);
    rd(4'h7);
    chk("run bit", rv, 32'h1);
    halt <= 1'b1;
    rd(4'hA);
    a = rv[7:0];
    rd(4'hA);
    chk("halted count", rv, {24'h0, a});
    wr(4'h8, 8'h01);
    rd(4'hA);
    a = rv[7:0];
    rd(4'hA);
    chk("bypass count", rv, {24'h0, a + 8'h03});
    halt <= 1'b0;
    wr(4'h8, 8'h00);
    $display("test prio done");
  endtask

  task automatic t_period;
    wirq(200);
    wr(4'h6, 8'h01);
    wirq(100);
    chk("period cycles", cyc, 32'd63);
    rd(4'h5);
    chk("irq enable", rv, 32'h1);
    rd(4'h6);
    chk("flag held", rv, 32'h1);
    wr(4'h5, 8'h00);
    @(negedge pclk);
    chk("irq masked", {31'h0, sample_irq}, 32'h0);
    $display("test period done");
  endtask

  task automatic t_meas(input logic [2:0] m, input logic e);
    @(posedge pclk);
    ev <= e;
    cfg(m, e, 1'b1);
    evw(~e, 5);
    evw(e, 7);
    evw(~e, 5);
    evw(e, 4);
    rd(4'h6);
    chk("capture flag", rv, 32'h1);
    rd(4'hC);
    chk("capture value", rv, (m == 3'h2) ? 32'hD : (m == 3'h3) ? 32'hB : 32'h4);
    @(negedge pclk);
    chk("flag after read", {31'h0, sample_irq}, 32'h0);
    $display("test meas mode %0d edge %0d done", m, e);
  endtask

  task automatic t_ignore;
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      ev   <= 1'b0;
      halt <= (k == 1);
      wr(4'hD, 8'hFF);
      wr(4'hC, 8'hFF);
      cfg((k == 3) ? 3'h7 : (k == 2) ? 3'h0 : 3'h3, 1'b0, k != 0);
      evw(1'b1, 5);
      evw(1'b0, 5);
      evw(1'b1, 5);
      @(negedge pclk);
      chk("ignored events", {31'h0, sample_irq}, 32'h0);
    end
    $display("test ignore done");
  endtask

  task automatic t_start;
    @(posedge pclk);
    ev <= 1'b0;
    wr(4'hD, 8'h00);
    wr(4'hC, 8'h60);
    cfg(3'h6, 1'b0, 1'b1);
    wr(4'hB, 8'h00);
    wr(4'hA, 8'h00);
    rd(4'h7);
    chk("single idle", rv, 32'h0);
    evw(1'b1, 3);
    rd(4'h7);
    chk("single started", rv, 32'h1);
    wirq(150);
    chk("single top flag", {31'h0, sample_irq}, 32'h1);
    rd(4'h7);
    chk("single stopped", rv, 32'h0);
    ev <= 1'b0;
    cfg(3'h1, 1'b0, 1'b1);
    evw(1'b1, 3);
    rd(4'h7);
    chk("timeout start", rv, 32'h1);
    evw(1'b0, 3);
    rd(4'h7);
    chk("timeout stop", rv, 32'h0);
    wr(4'hD, 8'h30);
    wr(4'hC, 8'hFF);
    cfg(3'h7, 1'b0, 1'b0);
    wirq(300);
    chk("pwm flag", {31'h0, sample_irq}, 32'h1);
    $display("test start done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    test_done;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev = 1'b0;
    halt = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_prio;
    t_period;
    for (int m = 2; m <= 5; m++) begin
      for (int e = 0; e <= 1; e++) begin
        t_meas(m[2:0], e[0]);
      end
    end
    t_ignore;
    t_start;
    test_done;
  end
endmodule // tb_top

bind tmb_event_capture tmb_event_capture_monitor #(.AW(AW)) i_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .event_in(event_in), .cpu_debug_halt(cpu_debug_halt), .sample_irq(sample_irq));
